// >>> hw/opb_bridge.sv
// opb_bridge: on-chip bus serving CPU byte/word accesses, bit read-modify-write,
// shared-address timer pair and port data/direction registers
// assumes the CPU holds a request until DONE, same clock; port pins are asynchronous
`timescale 1ns/10ps
module opb_bridge
  import opb_pkg::*;
#(
  parameter int ROM_WORDS = 16384,
  parameter int RAM_SIZE = RAM_BYTES
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic REQ,
  input wire logic WR,
  input wire logic WORD,
  input wire logic BITOP,
  input wire logic [2:0] BIT_OP,
  input wire logic [2:0] BIT_SEL,
  input wire logic BIT_C,
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic [7:0] PORT_IN,
  output logic [15:0] RDATA,
  output logic DONE,
  output logic [7:0] PORT_OUT,
  output logic [7:0] PORT_OE
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WAIT = 3'b001, ST_RMW_RD = 3'b010, ST_RMW_WR = 3'b011, ST_END = 3'b100
  } opb_st_e;

  opb_st_e st_r;
  opb_cls_e cls;
  logic [1:0] states;
  logic [1:0] cnt_r;
  logic [15:0] addr_r;
  logic wr_r, word_r, bitop_r;
  logic [2:0] bop_r, bsel_r;
  logic bc_r;
  logic [15:0] wdata_r;
  logic [7:0] rmw_r;
  logic [7:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
  logic [7:0] pdat_r, pdir_r;
  logic [15:0] ram_mem [RAM_SIZE/2];
  logic [15:0] rom_mem [ROM_WORDS];
  logic [7:0] tmr_count, tmr_load;
  logic tmr_we;
  logic [15:0] rd_word;
  logic [7:0] rd_byte;
  logic wr_go;
  logic [7:0] wr_byte;
  logic pdat_hit, pdir_hit, tmr_hit;
  logic [7:0] rmw_src;
  logic [15:0] RDATA_r;
  logic DONE_r;

  opb_decode u_dec (
    .addr(addr_r),
    .cls(cls),
    .states(states)
  );

  opb_tmr u_tmr (
    .clk(MCLK),
    .rst(RST),
    .load_we(tmr_we),
    .load_d(wr_byte),
    .count(tmr_count),
    .load_val(tmr_load)
  );

  // single-register decodes in the 96-byte window
  assign pdat_hit = (addr_r == PDAT_ADDR);
  assign pdir_hit = (addr_r == PDIR_ADDR);
  assign tmr_hit = (addr_r == TMR_ADDR);

  // word index inside the RAM block
  function automatic logic [8:0] ram_idx(input logic [15:0] a);
    return 9'(a[9:1] - RAM_LO[9:1]);
  endfunction

  // byte onto the lane its address selects, the other lane undefined
  function automatic logic [15:0] lane_put(input logic [7:0] b, input logic upper);
    return upper ? {b, UNDEF_BYTE} : {UNDEF_BYTE, b};
  endfunction

  function automatic logic [7:0] bit_mod(input logic [7:0] d, input logic [2:0] op, input logic [2:0] sel,
                                         input logic c);
    logic [7:0] r;
    r = d;
    case (op)
      BOP_SET: r[sel] = 1'b1;
      BOP_CLR: r[sel] = 1'b0;
      BOP_INV: r[sel] = ~d[sel];
      BOP_ST: r[sel] = c;
      default: r[sel] = ~c;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] io_read(input logic [15:0] a, input logic [7:0] pdat, input logic [7:0] pdir,
                                         input logic [7:0] pin, input logic [7:0] tc);
    if (a == PDAT_ADDR) begin
      return (pdir & pdat) | (~pdir & pin);
    end else if (a == PDIR_ADDR) begin
      return WO_READ;
    end else if (a == TMR_ADDR) begin
      return tc;
    end else begin
      return UNDEF_BYTE;
    end
  endfunction

  // pin synchroniser: change accepted when stages two and three agree
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pin_s3_r <= 8'h00;
      pin_r <= 8'h00;
    end else begin
      pin_s1_r <= PORT_IN;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (int i = 0; i < 8; i++) begin
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_r[i] <= pin_s3_r[i];
        end
      end
    end
  end

  // read data before lane steering
  always_comb begin
    rd_word = {UNDEF_BYTE, UNDEF_BYTE};
    rd_byte = UNDEF_BYTE;
    if (cls == CLS_ROM) begin
      rd_word = rom_mem[addr_r[14:1]];
    end else if (cls == CLS_RAM) begin
      rd_word = ram_mem[ram_idx(addr_r)];
    end else if (cls == CLS_IO2 || cls == CLS_IO3) begin
      rd_byte = io_read(addr_r, pdat_r, pdir_r, pin_r, tmr_count);
    end
    // io bytes ride the lane of their address, io words the upper lane
    if (cls != CLS_ROM && cls != CLS_RAM && cls != CLS_EMPTY) begin
      rd_word = lane_put(rd_byte, word_r || !addr_r[0]);
    end
  end

  // write byte for I/O: upper byte of a word, or byte on the upper lane of even address
  always_comb begin
    if (bitop_r) begin
      wr_byte = rmw_r;
    end else if (word_r || !addr_r[0]) begin
      wr_byte = wdata_r[15:8];
    end else begin
      wr_byte = wdata_r[7:0];
    end
  end

  // writes reach only RAM, port and timer registers; all else is dropped
  assign wr_go = (st_r == ST_RMW_WR) || (st_r == ST_WAIT && wr_r && !bitop_r && cnt_r == 2'h1);
  assign tmr_we = wr_go && tmr_hit;

  // bit operations read the lane their address selects
  assign rmw_src = addr_r[0] ? rd_word[7:0] : rd_word[15:8];

  // access sequencer
  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_r <= ST_IDLE;
      cnt_r <= 2'h0;
      addr_r <= 16'h0000;
      wr_r <= 1'b0;
      word_r <= 1'b0;
      bitop_r <= 1'b0;
      bop_r <= BOP_SET;
      bsel_r <= 3'h0;
      bc_r <= 1'b0;
      wdata_r <= 16'h0000;
      rmw_r <= 8'h00;
      DONE_r <= 1'b0;
      RDATA_r <= 16'h0000;
    end else begin
      DONE_r <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (REQ) begin
            addr_r <= ADDR;
            wr_r <= WR;
            word_r <= WORD & ~BITOP;
            bitop_r <= BITOP;
            bop_r <= BIT_OP;
            bsel_r <= BIT_SEL;
            bc_r <= BIT_C;
            wdata_r <= WDATA;
            st_r <= BITOP ? ST_RMW_RD : ST_WAIT;
            cnt_r <= 2'h0;
          end
        end
        ST_WAIT: begin
          if (cnt_r == 2'h0) begin
            cnt_r <= states - 2'h1;
          end else if (cnt_r == 2'h1) begin
            // plain writes land on this edge too
            RDATA_r <= wr_r ? 16'h0000 : rd_word;
            DONE_r <= 1'b1;
            st_r <= ST_END;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
        ST_RMW_RD: begin
          // byte read then single-bit modify, before any write
          rmw_r <= bit_mod(rmw_src, bop_r, bsel_r, bc_r);
          st_r <= ST_RMW_WR;
        end
        ST_RMW_WR: begin
          DONE_r <= 1'b1;
          RDATA_r <= {rmw_r, rmw_r};
          st_r <= ST_END;
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // on-chip RAM, byte or word
  always_ff @(posedge MCLK) begin
    if (wr_go && cls == CLS_RAM) begin
      if (word_r) begin
        ram_mem[ram_idx(addr_r)] <= wdata_r;
      end else if (addr_r[0]) begin
        ram_mem[ram_idx(addr_r)][7:0] <= bitop_r ? rmw_r : wdata_r[7:0];
      end else begin
        ram_mem[ram_idx(addr_r)][15:8] <= bitop_r ? rmw_r : wdata_r[15:8];
      end
    end
  end

  // ROM contents are fixed; writes ignored
  always_comb begin
    for (int i = 0; i < ROM_WORDS; i++) begin
      rom_mem[i] = 16'h0000;
    end
  end

  // port data: all eight bits stored on a write
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pdat_r <= PDAT_RST;
    end else if (wr_go && pdat_hit) begin
      pdat_r <= wr_byte;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      pdir_r <= PDIR_RST;
    end else if (wr_go && pdir_hit) begin
      pdir_r <= wr_byte;
    end
  end

  // pins follow the registers one clock later
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PORT_OUT <= PDAT_RST;
      PORT_OE <= PDIR_RST;
    end else begin
      PORT_OUT <= pdat_r;
      PORT_OE <= pdir_r;
    end
  end

  assign RDATA = RDATA_r;
  assign DONE = DONE_r;
endmodule // opb_bridge

// >>> hw/opb_pkg.sv
// opb_pkg: address map, timing and encodings for the on-chip peripheral bus bridge
// assumes one clock; all counts in states of that clock
package opb_pkg;
  localparam logic [15:0] VEC_LO = 16'h0000;
  localparam logic [15:0] VEC_HI = 16'h002F;
  localparam logic [15:0] ROM_LO = 16'h0030;
  localparam logic [15:0] ROM_HI = 16'h7FFF;
  localparam logic [15:0] IO16_LO = 16'hF770;
  localparam logic [15:0] IO16_HI = 16'hF77F;
  localparam logic [15:0] RAM_LO = 16'hFB80;
  localparam logic [15:0] RAM_HI = 16'hFF7F;
  localparam logic [15:0] IO96_LO = 16'hFFA0;
  localparam logic [15:0] IO96_HI = 16'hFFFF;
  localparam logic [15:0] SER_LO = 16'hFFA8;
  localparam logic [15:0] SER_HI = 16'hFFAD;
  localparam logic [15:0] CMPT_LO = 16'hFFB8;
  localparam logic [15:0] CMPT_HI = 16'hFFBD;
  localparam logic [15:0] TMR_ADDR = 16'hFFB3;
  localparam logic [15:0] PDIR_ADDR = 16'hFFE6;
  localparam logic [15:0] PDAT_ADDR = 16'hFFD6;
  localparam int RAM_BYTES = 1024;
  localparam logic [1:0] STATES_2 = 2'h2;
  localparam logic [1:0] STATES_3 = 2'h3;
  localparam logic [7:0] WO_READ = 8'hFF;
  localparam logic [7:0] UNDEF_BYTE = 8'h00;
  localparam logic [7:0] PDAT_RST = 8'h00;
  localparam logic [7:0] PDIR_RST = 8'h00;
  localparam logic [7:0] TMR_RST = 8'h00;
  localparam logic [2:0] BOP_SET = 3'h0;
  localparam logic [2:0] BOP_CLR = 3'h1;
  localparam logic [2:0] BOP_INV = 3'h2;
  localparam logic [2:0] BOP_ST = 3'h3;
  localparam logic [2:0] BOP_IST = 3'h4;
  typedef enum logic [2:0] {
    CLS_EMPTY = 3'b000, CLS_ROM = 3'b001, CLS_RAM = 3'b010, CLS_IO3 = 3'b011, CLS_IO2 = 3'b100
  } opb_cls_e;
endpackage

// >>> hw/opb_decode.sv
// opb_decode: classifies an address into region class and state count
// assumes a combinational address from the same clock domain
`timescale 1ns/10ps
module opb_decode
  import opb_pkg::*;
(
  input wire logic [15:0] addr,
  output opb_cls_e cls,
  output logic [1:0] states
);
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
  always_comb begin
    if (in_rng(addr, ROM_LO, ROM_HI)) begin
      cls = CLS_ROM;
    end else if (in_rng(addr, VEC_LO, VEC_HI)) begin
      cls = CLS_ROM;
    end else if (in_rng(addr, RAM_LO, RAM_HI)) begin
      cls = CLS_RAM;
    end else if (in_rng(addr, IO16_LO, IO16_HI)) begin
      cls = CLS_IO3;
    end else if (in_rng(addr, SER_LO, SER_HI) || in_rng(addr, CMPT_LO, CMPT_HI)) begin
      cls = CLS_IO3;
    end else if (in_rng(addr, IO96_LO, IO96_HI)) begin
      cls = CLS_IO2;
    end else begin
      cls = CLS_EMPTY;
    end
    states = (cls == CLS_IO3) ? STATES_3 : STATES_2;
  end
endmodule // opb_decode

// >>> hw/opb_tmr.sv
// opb_tmr: reloadable up-counter sharing one address with its load register
// assumes load strobe from the bus bridge on the same clock
`timescale 1ns/10ps
module opb_tmr
  import opb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load_we,
  input wire logic [7:0] load_d,
  output logic [7:0] count,
  output logic [7:0] load_val
);
  logic [7:0] count_r;
  logic [7:0] load_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      load_r <= TMR_RST;
    end else if (load_we) begin
      load_r <= load_d;
    end
  end
  // counts freely, reloads on overflow
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= TMR_RST;
    end else if (count_r == 8'hFF) begin
      count_r <= load_r;
    end else begin
      count_r <= count_r + 8'h01;
    end
  end
  assign count = count_r;
  assign load_val = load_r;
endmodule // opb_tmr

// >>> bench/opb_sva.sv
// opb_sva: state counts and read-back checks at the bridge ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module opb_sva
  import opb_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic REQ,
  input wire logic WR,
  input wire logic WORD,
  input wire logic BITOP,
  input wire logic [15:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic [15:0] RDATA,
  input wire logic DONE,
  input wire logic [7:0] PORT_OE
);
  logic io3;
  logic rd1;
  logic [7:0] wd_r;
  assign io3 = ADDR inside {[IO16_LO:IO16_HI], [SER_LO:SER_HI], [CMPT_LO:CMPT_HI]};
  assign rd1 = DONE && !WR && !BITOP;
  always_ff @(posedge MCLK) begin
    if (DONE && WR) wd_r <= WDATA[15:8];
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  a_mem_states: assert property ($rose(REQ) && !BITOP && (ADDR <= ROM_HI || ADDR inside {[RAM_LO:RAM_HI]})
    |-> !DONE [*3] ##1 DONE) else $error("memory access length wrong");
  a_io2_states: assert property ($rose(REQ) && !BITOP && ADDR >= IO96_LO && !io3
    |-> !DONE [*3] ##1 DONE) else $error("two-state io length wrong");
  a_io3_states: assert property ($rose(REQ) && !BITOP && io3
    |-> !DONE [*4] ##1 DONE) else $error("three-state io length wrong");
  a_bit_states: assert property ($rose(REQ) && BITOP
    |-> !DONE [*3] ##1 DONE) else $error("bit operation length wrong");
  a_done_pulse: assert property (DONE |=> !DONE [*2]) else $error("done longer than a pulse");
  a_dir_ones: assert property (rd1 && ADDR == PDIR_ADDR |-> RDATA[15:8] == WO_READ)
    else $error("direction read not all ones");
  a_word_low: assert property (rd1 && WORD && ADDR >= IO96_LO |-> RDATA[7:0] == UNDEF_BYTE)
    else $error("io word low byte wrong");
  a_dir_enable: assert property (DONE && WR && ADDR == PDIR_ADDR |-> ##[1:2] PORT_OE == wd_r)
    else $error("enables do not follow direction");
endmodule // opb_sva
bind opb_bridge opb_sva i_sva (.MCLK, .RST, .REQ, .WR, .WORD, .BITOP, .ADDR, .WDATA, .RDATA, .DONE, .PORT_OE);

// >>> bench/opb_cpu.sv
// opb_cpu: behavioural CPU core issuing byte, word and bit accesses
// assumes requests change at falling edges and DONE is a registered pulse
`timescale 1ns/10ps
module opb_cpu (
  input wire logic clk,
  input wire logic done,
  output logic req,
  output logic wr,
  output logic word,
  output logic bitop,
  output logic [2:0] bit_op,
  output logic [2:0] bit_sel,
  output logic bit_c,
  output logic [15:0] addr,
  output logic [15:0] wdata
);
  initial {req, wr, word, bitop, bit_op, bit_sel, bit_c, addr, wdata} = '0;
  // byte access is used for io unless a scenario asks for a word
  task automatic access(input logic w, input logic wd, input logic b, input logic [2:0] op, input logic [2:0] sel,
    input logic c, input logic [15:0] a, input logic [15:0] d, output int lat);
    lat = 0;
    @(negedge clk);
    {wr, word, bitop, bit_op, bit_sel, bit_c, addr, wdata} = {w, wd, b, op, sel, c, a, d};
    req = 1'b1;
    while (done !== 1'b1 && lat < 50) begin
      @(negedge clk);
      lat++;
    end
    // hold through the edge that samples DONE, then release
    @(negedge clk);
    req = 1'b0;
    // released lines stop showing the request
    addr = ~addr;
    wdata = ~wdata;
  endtask
endmodule // opb_cpu

// >>> bench/tb.sv
// tb: self-checking bench for the on-chip bus bridge
// assumes opb_cpu issues requests; pin levels are modelled here
`timescale 1ns/10ps
module tb;
  import opb_pkg::*;
  logic mclk, rst, done, req, wr, word, bitop, bit_c;
  logic [2:0] bit_op, bit_sel;
  logic [15:0] addr, wdata, rdata;
  logic [7:0] port_in, port_out, port_oe, pin_ext, v, w;
  int bad_count, total_checks, lat;
  assign port_in = (port_oe & port_out) | (~port_oe & pin_ext);
  opb_cpu i_cpu (.clk(mclk), .done(done), .req(req), .wr(wr), .word(word), .bitop(bitop), .bit_op(bit_op),
    .bit_sel(bit_sel), .bit_c(bit_c), .addr(addr), .wdata(wdata));
  opb_bridge i_dut (.MCLK(mclk), .RST(rst), .REQ(req), .WR(wr), .WORD(word), .BITOP(bitop), .BIT_OP(bit_op),
    .BIT_SEL(bit_sel), .BIT_C(bit_c), .ADDR(addr), .WDATA(wdata), .PORT_IN(port_in), .RDATA(rdata),
    .DONE(done), .PORT_OUT(port_out), .PORT_OE(port_oe));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic w_i, input logic wd, input logic [15:0] a, input logic [15:0] d);
    i_cpu.access(w_i, wd, 1'b0, 3'h0, 3'h0, 1'b0, a, d, lat);
    v = a[0] ? rdata[7:0] : rdata[15:8];
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
    acc(1'b1, 1'b0, a, a[0] ? {8'h00, d} : {d, 8'h00});
  endtask
  task automatic bop(input logic [2:0] op, input logic [2:0] sel, input logic [15:0] a);
    i_cpu.access(1'b0, 1'b0, 1'b1, op, sel, 1'b1, a, 16'h0000, lat);
    v = rdata[15:8];
  endtask
  task automatic t_mem;
    acc(1'b1, 1'b1, RAM_LO, 16'hA55A);
    check("ram states", 16'h0003, 16'(lat));
    acc(1'b0, 1'b1, RAM_LO, 16'h0000);
    check("ram word", 16'hA55A, rdata);
    acc(1'b0, 1'b0, RAM_LO + 16'h1, 16'h0000);
    check("ram odd byte", 8'h5A, v);
    wr8(RAM_HI, 8'h3C);
    acc(1'b0, 1'b1, ROM_LO, 16'h0000);
    check("rom states", 16'h0003, 16'(lat));
    acc(1'b0, 1'b0, VEC_LO, 16'h0000);
    check("vector states", 16'h0003, 16'(lat));
    $display("test mem done");
  endtask
  task automatic t_io;
    wr8(PDIR_ADDR, 8'hFF);
    acc(1'b1, 1'b1, PDAT_ADDR, 16'h5AA5);
    acc(1'b0, 1'b1, PDAT_ADDR, 16'h0000);
    check("io word", {8'h5A, UNDEF_BYTE}, rdata);
    check("port out", 8'h5A, port_out);
    acc(1'b0, 1'b0, IO16_LO, 16'h0000);
    check("io16 states", 16'h0004, 16'(lat));
    acc(1'b0, 1'b0, SER_LO, 16'h0000);
    check("serial states", 16'h0004, 16'(lat));
    acc(1'b0, 1'b0, CMPT_HI, 16'h0000);
    check("compare states", 16'h0004, 16'(lat));
    acc(1'b0, 1'b0, SER_HI + 16'h1, 16'h0000);
    check("io2 states", 16'h0003, 16'(lat));
    wr8(16'hFF80, 8'h77);
    acc(1'b0, 1'b0, 16'hFF80, 16'h0000);
    check("empty read", UNDEF_BYTE, v);
    acc(1'b0, 1'b0, RAM_HI, 16'h0000);
    check("ram beside empty", 8'h3C, v);
    $display("test io done");
  endtask
  task automatic t_port;
    wr8(PDIR_ADDR, 8'h3F);
    check("enables", 8'h3F, port_oe);
    acc(1'b0, 1'b0, PDIR_ADDR, 16'h0000);
    check("dir read", WO_READ, v);
    wr8(PDAT_ADDR, 8'h80);
    pin_ext = 8'h40;
    repeat (8) @(negedge mclk);
    acc(1'b0, 1'b0, PDAT_ADDR, 16'h0000);
    check("port read", 8'h40, v);
    bop(BOP_SET, 3'h0, PDAT_ADDR);
    check("set on port", 8'h41, v);
    check("port after set", 8'h41, port_out);
    bop(BOP_CLR, 3'h0, PDIR_ADDR);
    check("dir after clear", 8'hFE, port_oe);
    wr8(RAM_LO + 16'h4, 8'h80);
    bop(BOP_SET, 3'h0, RAM_LO + 16'h4);
    acc(1'b0, 1'b0, RAM_LO + 16'h4, 16'h0000);
    wr8(PDAT_ADDR, v);
    check("port from shadow", 8'h81, port_out);
    acc(1'b0, 1'b0, PDAT_ADDR, 16'h0000);
    check("port shadow read", 8'h80, v);
    $display("test port done");
  endtask
  task automatic t_bits;
    logic [7:0] e;
    wr8(RAM_LO + 16'h2, 8'hA5);
    e = 8'hA5;
    for (int k = 0; k < 5; k++) begin
      case (k)
        0: e[1] = 1'b1;
        1: e[2] = 1'b0;
        2: e[3] = ~e[3];
        3: e[4] = 1'b1;
        default: e[5] = 1'b0;
      endcase
      bop(3'(k), 3'(k + 1), RAM_LO + 16'h2);
      check("bit op", e, v);
    end
    acc(1'b0, 1'b0, RAM_LO + 16'h2, 16'h0000);
    check("bit op stored", e, v);
    wr8(TMR_ADDR, 8'hF0);
    acc(1'b0, 1'b0, TMR_ADDR, 16'h0000);
    w = v;
    repeat (5) @(negedge mclk);
    acc(1'b0, 1'b0, TMR_ADDR, 16'h0000);
    check("counter runs", 1'b1, v !== w);
    $display("test bits done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    pin_ext = 8'h00;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    check("oe after reset", 8'h00, port_oe);
    t_mem();
    t_io();
    t_port();
    t_bits();
    report_and_stop();
  end
endmodule // tb
